// ==== rtl/oss_pkg.sv ====
/*
 * Shared constants and types of the oscillator source switch.
 * Assumes a 32-bit APB slave port and one 50 MHz core clock.
 */
package oss_pkg;
   // Register byte addresses
   localparam logic [7:0] OSS_TRIM_ADDR = 8'h38;
   localparam logic [7:0] OSS_STAT_ADDR = 8'h3C;
   localparam logic [7:0] OSS_CONF_ADDR = 8'h40;

   // Reset values
   localparam logic [7:0] OSS_TRIM_RESET = 8'h80;
   localparam logic [1:0] OSS_SEL_RESET = 2'h0;

   // Field positions
   localparam int OSS_STAT_REQ_BIT = 0;
   localparam int OSS_STAT_ENG_BIT = 1;
   localparam int OSS_CONF_SEL_LSB = 0;
   localparam int OSS_CONF_OUTEN_BIT = 2;

   // Core clock rate
   localparam int OSS_CORE_CLK_MHZ = 50;

   // Source select codes
   typedef enum logic [1:0] {
      OSS_SRC_INT  = 2'b00,
      OSS_SRC_EXT  = 2'b01,
      OSS_SRC_RC   = 2'b10,
      OSS_SRC_XTAL = 2'b11
   } oss_src_type;

   // Function of the shared second oscillator pin
   typedef enum logic [1:0] {
      OSS_PIN_PORT   = 2'b00,
      OSS_PIN_AMP    = 2'b01,
      OSS_PIN_CLKOUT = 2'b10
   } oss_pin_fn_type;

   // Switch sequence states
   typedef enum logic [2:0] {
      OSS_SW_INT   = 3'b000,
      OSS_SW_EDGE1 = 3'b001,
      OSS_SW_EDGE2 = 3'b010,
      OSS_SW_ALIGN = 3'b011,
      OSS_SW_FLAG  = 3'b100,
      OSS_SW_EXT   = 3'b101
   } oss_sw_type;

   // Status register contents
   typedef struct packed {
      logic engaged;
      logic request;
   } oss_stat_type;

   // Second pin drive
   typedef struct packed {
      logic drive;
      logic oe_n;
   } oss_pin_type;
endpackage

// ==== rtl/oss_sync.sv ====
/*
 * Two-stage synchroniser for pin inputs.
 * Assumes the input is asynchronous to core_clk.
 */
`timescale 1ns/1ns
module oss_sync #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_r;

   // First stage feeds only the second
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         meta_r <= '0;
         dout <= '0;
      end else if (ce) begin
         meta_r <= din;
         dout <= meta_r;
      end
   end
endmodule // oss_sync

// ==== rtl/oss_int_osc.sv ====
/*
 * Digital model of the trimmable internal oscillator.
 * Assumes the trim value and run enable come from core_clk logic.
 */
`timescale 1ns/1ns
module oss_int_osc #(
   parameter int TRIM_BASE = 1
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic run,
   input wire logic [7:0] trim,
   output logic osc_lvl
);
   logic [8:0] cnt_r;
   logic [8:0] half_len;

   generate
      if (TRIM_BASE < 1 || TRIM_BASE > 255) begin : g_bad_base
         $error("TRIM_BASE out of range");
      end
   endgenerate

   // Larger trim gives a longer half period
   assign half_len = 9'(TRIM_BASE) + {1'b0, trim};

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 9'h000;
         osc_lvl <= 1'b0;
      end else if (ce) begin
         if (!run) begin
            cnt_r <= 9'h000;
            osc_lvl <= 1'b0;
         end else if (cnt_r + 9'h001 >= half_len) begin
            cnt_r <= 9'h000;
            osc_lvl <= ~osc_lvl;
         end else begin
            cnt_r <= cnt_r + 9'h001;
         end
      end
   end
endmodule // oss_int_osc

// ==== rtl/oss_source_switch.sv ====
/*
 * Oscillator source selection, glitch-free switch to an external clock,
 * trim register and second-pin function, with an APB register port.
 * Assumes all clocks are modelled as levels sampled by core_clk.
 */
// The APB register port was chosen for this implementation.
// Summary of operation
// - Drive source clock and half-rate clock
// - Run from internal oscillator after reset
// - 8-bit trim; larger value, longer period
// - Trim resets to midpoint 0x80
// - External select makes pin one a clock input
// - Wait two external rising edges first
// - Switch without glitch or short pulse
// - Set engaged flag, then stop internal oscillator
// - Internal restarts only on reset; no fallback
// - Direct clock drives source, halved for half-rate
// - Direct clock: pin two is port I/O
// - Crystal: pin two is amplifier output
// - Internal/RC: output enable picks clock or port
// - Select codes: internal, direct, RC, crystal
// - Switch request cleared by reset
// - Stop halts source, half-rate and output clocks
`timescale 1ns/1ns
module oss_source_switch #(
   parameter int TRIM_BASE = 1
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic stop_mode,
   input wire logic clock_in_pin,
   output logic clock_in_enable,
   output logic clock_out_pin_o,
   output logic clock_out_pin_oe_n,
   output logic [1:0] clock_out_fn,
   output logic source_rate_clock,
   output logic half_rate_clock,
   output logic internal_osc_run
);
   // Register state
   logic [7:0] trim_register_r;
   oss_pkg::oss_src_type source_select_r;
   logic clock_out_enable_r;
   logic external_switch_request_r;
   logic external_engaged_status_r;

   // Bus handshake state
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [31:0] rd_nxt;
   logic bus_access;
   logic bus_start;
   logic wr_en;

   // Clock path state
   logic ext_lvl;
   logic ext_prev_r;
   logic ext_rise;
   logic int_lvl;
   logic src_lvl;
   logic src_r;
   logic half_r;
   logic sel_ext_r;
   logic run_r;
   oss_pkg::oss_sw_type sw_state_r;
   oss_pkg::oss_sw_type sw_state_nxt;

   // Pin function state
   oss_pkg::oss_pin_fn_type pin_fn_now;
   oss_pkg::oss_pin_type pin_nxt;
   logic clock_in_enable_r;
   logic clock_out_pin_r;
   logic clock_out_oe_n_r;
   logic [1:0] clock_out_fn_r;

   generate
      if (TRIM_BASE < 1 || TRIM_BASE > 255) begin : g_bad_base
         $error("TRIM_BASE out of range");
      end
   endgenerate

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_a);
      return a == reg_a;
   endfunction

   function automatic logic addr_known(input logic [7:0] a);
      return addr_hit(a, oss_pkg::OSS_TRIM_ADDR)
         || addr_hit(a, oss_pkg::OSS_STAT_ADDR)
         || addr_hit(a, oss_pkg::OSS_CONF_ADDR);
   endfunction

   // Function of the second pin for a select code and enable
   function automatic oss_pkg::oss_pin_fn_type pin_fn(
      input oss_pkg::oss_src_type sel,
      input logic outen
   );
      oss_pkg::oss_pin_fn_type fn;
      case (sel)
         oss_pkg::OSS_SRC_XTAL: begin
            fn = oss_pkg::OSS_PIN_AMP;
         end
         oss_pkg::OSS_SRC_EXT: begin
            fn = oss_pkg::OSS_PIN_PORT;
         end
         default: begin
            if (outen) begin
               fn = oss_pkg::OSS_PIN_CLKOUT;
            end else begin
               fn = oss_pkg::OSS_PIN_PORT;
            end
         end
      endcase
      return fn;
   endfunction

   // Bus qualifiers
   assign bus_access = psel && penable;
   assign bus_start = bus_access && !pready_r;
   assign wr_en = bus_access && pready_r && pwrite;

   // One wait state: ready rises one cycle into the access phase
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pready_r <= 1'b0;
      end else if (ce) begin
         pready_r <= bus_start;
      end
   end

   // Unmapped addresses answer with an error
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pslverr_r <= 1'b0;
      end else if (ce) begin
         pslverr_r <= bus_start && !addr_known(paddr);
      end
   end

   // Read word of the addressed register
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (addr_hit(paddr, oss_pkg::OSS_TRIM_ADDR)) begin
         rd_nxt[7:0] = trim_register_r;
      end else if (addr_hit(paddr, oss_pkg::OSS_STAT_ADDR)) begin
         rd_nxt[oss_pkg::OSS_STAT_REQ_BIT] = external_switch_request_r;
         rd_nxt[oss_pkg::OSS_STAT_ENG_BIT] = external_engaged_status_r;
      end else if (addr_hit(paddr, oss_pkg::OSS_CONF_ADDR)) begin
         rd_nxt[oss_pkg::OSS_CONF_SEL_LSB +: 2] = source_select_r;
         rd_nxt[oss_pkg::OSS_CONF_OUTEN_BIT] = clock_out_enable_r;
      end
   end

   // Read data is held until the transfer completes
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prdata_r <= 32'h0000_0000;
      end else if (ce) begin
         if (bus_start) begin
            if (pwrite) begin
               prdata_r <= 32'h0000_0000;
            end else begin
               prdata_r <= rd_nxt;
            end
         end
      end
   end

   // Trim register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         trim_register_r <= oss_pkg::OSS_TRIM_RESET;
      end else if (ce) begin
         if (wr_en && pstrb[0] && addr_hit(paddr, oss_pkg::OSS_TRIM_ADDR)) begin
            trim_register_r <= pwdata[7:0];
         end
      end
   end

   // Switch request bit
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         external_switch_request_r <= 1'b0;
      end else if (ce) begin
         if (wr_en && pstrb[0] && addr_hit(paddr, oss_pkg::OSS_STAT_ADDR)) begin
            external_switch_request_r <= pwdata[oss_pkg::OSS_STAT_REQ_BIT];
         end
      end
   end

   // Source select and clock output enable
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         source_select_r <= oss_pkg::oss_src_type'(oss_pkg::OSS_SEL_RESET);
         clock_out_enable_r <= 1'b0;
      end else if (ce) begin
         if (wr_en && pstrb[0] && addr_hit(paddr, oss_pkg::OSS_CONF_ADDR)) begin
            source_select_r <= oss_pkg::oss_src_type'(pwdata[oss_pkg::OSS_CONF_SEL_LSB +: 2]);
            clock_out_enable_r <= pwdata[oss_pkg::OSS_CONF_OUTEN_BIT];
         end
      end
   end

   // Clock pin passes two flip-flops
   oss_sync #(
      .W(1)
   ) u_pin_sync (
      .core_clk(core_clk),
      .nrst(nrst),
      .ce(ce),
      .din(clock_in_pin),
      .dout(ext_lvl)
   );

   // Internal oscillator
   oss_int_osc #(
      .TRIM_BASE(TRIM_BASE)
   ) u_int_osc (
      .core_clk(core_clk),
      .nrst(nrst),
      .ce(ce),
      .run(run_r),
      .trim(trim_register_r),
      .osc_lvl(int_lvl)
   );

   // Rising edges of the external clock; idle level is low
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ext_prev_r <= 1'b0;
      end else if (ce) begin
         ext_prev_r <= ext_lvl;
      end
   end

   assign ext_rise = ext_lvl && !ext_prev_r;

   // Switch sequence
   always_comb begin
      sw_state_nxt = sw_state_r;
      case (sw_state_r)
         oss_pkg::OSS_SW_INT: begin
            if (external_switch_request_r && source_select_r != oss_pkg::OSS_SRC_INT) begin
               sw_state_nxt = oss_pkg::OSS_SW_EDGE1;
            end
         end
         oss_pkg::OSS_SW_EDGE1: begin
            if (ext_rise) begin
               sw_state_nxt = oss_pkg::OSS_SW_EDGE2;
            end
         end
         oss_pkg::OSS_SW_EDGE2: begin
            if (ext_rise) begin
               sw_state_nxt = oss_pkg::OSS_SW_ALIGN;
            end
         end
         oss_pkg::OSS_SW_ALIGN: begin
            if (!ext_lvl && !int_lvl) begin
               sw_state_nxt = oss_pkg::OSS_SW_FLAG;
            end
         end
         oss_pkg::OSS_SW_FLAG: begin
            sw_state_nxt = oss_pkg::OSS_SW_EXT;
         end
         oss_pkg::OSS_SW_EXT: begin
            sw_state_nxt = oss_pkg::OSS_SW_EXT;
         end
         default: begin
            sw_state_nxt = oss_pkg::OSS_SW_INT;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sw_state_r <= oss_pkg::OSS_SW_INT;
      end else if (ce) begin
         sw_state_r <= sw_state_nxt;
      end
   end

   // Mux moves only while both clocks are low
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sel_ext_r <= 1'b0;
      end else if (ce) begin
         if (sw_state_r == oss_pkg::OSS_SW_ALIGN && sw_state_nxt == oss_pkg::OSS_SW_FLAG) begin
            sel_ext_r <= 1'b1;
         end
      end
   end

   // Engaged flag comes before the oscillator stops
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         external_engaged_status_r <= 1'b0;
      end else if (ce) begin
         if (sw_state_r == oss_pkg::OSS_SW_FLAG) begin
            external_engaged_status_r <= 1'b1;
         end
      end
   end

   // Internal oscillator restarts only through reset
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         run_r <= 1'b1;
      end else if (ce) begin
         if (sw_state_r == oss_pkg::OSS_SW_EXT) begin
            run_r <= 1'b0;
         end
      end
   end

   // Selected source level
   assign src_lvl = sel_ext_r ? ext_lvl : int_lvl;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         src_r <= 1'b0;
      end else if (ce) begin
         if (stop_mode) begin
            src_r <= 1'b0;
         end else begin
            src_r <= src_lvl;
         end
      end
   end

   // Half rate toggles on each rising source edge
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         half_r <= 1'b0;
      end else if (ce) begin
         if (!stop_mode && src_lvl && !src_r) begin
            half_r <= ~half_r;
         end
      end
   end

   // Second pin drive
   assign pin_fn_now = pin_fn(source_select_r, clock_out_enable_r);

   always_comb begin
      pin_nxt.drive = 1'b0;
      pin_nxt.oe_n = 1'b1;
      case (pin_fn_now)
         oss_pkg::OSS_PIN_CLKOUT: begin
            pin_nxt.drive = src_lvl && !stop_mode;
            pin_nxt.oe_n = 1'b0;
         end
         oss_pkg::OSS_PIN_AMP: begin
            pin_nxt.drive = !ext_lvl;
            pin_nxt.oe_n = 1'b0;
         end
         default: begin
            pin_nxt.drive = 1'b0;
            pin_nxt.oe_n = 1'b1;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         clock_in_enable_r <= 1'b0;
         clock_out_pin_r <= 1'b0;
         clock_out_oe_n_r <= 1'b1;
         clock_out_fn_r <= 2'h0;
      end else if (ce) begin
         clock_in_enable_r <= (source_select_r != oss_pkg::OSS_SRC_INT);
         clock_out_pin_r <= pin_nxt.drive;
         clock_out_oe_n_r <= pin_nxt.oe_n;
         clock_out_fn_r <= pin_fn_now;
      end
   end

   // Outputs straight from flip-flops
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign clock_in_enable = clock_in_enable_r;
   assign clock_out_pin_o = clock_out_pin_r;
   assign clock_out_pin_oe_n = clock_out_oe_n_r;
   assign clock_out_fn = clock_out_fn_r;
   assign source_rate_clock = src_r;
   assign half_rate_clock = half_r;
   assign internal_osc_run = run_r;
endmodule // oss_source_switch

// ==== tb/oss_ext_src.sv ====
/* External clock source model. Assumes en comes from the bench. */
`timescale 1ns/1ns
module oss_ext_src (
   input wire logic en,
   output logic clk
);
   initial clk = 1'b0;
   // Runs only while enabled, idles low; no precharge modelled
   always #37 clk = en ? ~clk : 1'b0;
endmodule // oss_ext_src

// ==== tb/oss_source_switch_chk.sv ====
/* Port checker of the source switch. Assumes a bind to the top. */
`timescale 1ns/1ns
module oss_source_switch_chk (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic stop_mode,
   input wire logic clock_in_enable,
   input wire logic clock_out_pin_oe_n,
   input wire logic [1:0] clock_out_fn,
   input wire logic source_rate_clock,
   input wire logic half_rate_clock,
   input wire logic internal_osc_run
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   run_after_rst_a: assert property ($rose(nrst) |-> internal_osc_run) else $error("off");
   stays_off_a: assert property (!internal_osc_run |=> !internal_osc_run) else $error("on");
   stop_ext_a: assert property ($fell(internal_osc_run) |-> clock_in_enable) else $error("s");
   half_edge_a: assert property ($changed(half_rate_clock) |-> source_rate_clock)
      else $error("half");
   stop_halt_a: assert property (stop_mode [*3] |-> $stable(source_rate_clock)) else $error("st");
   clkout_drv_a: assert property (clock_out_fn == oss_pkg::OSS_PIN_CLKOUT |-> !clock_out_pin_oe_n)
      else $error("oe");
   amp_in_a: assert property (clock_out_fn == oss_pkg::OSS_PIN_AMP |-> clock_in_enable)
      else $error("amp");
   port_free_a: assert property (clock_out_fn == oss_pkg::OSS_PIN_PORT |-> clock_out_pin_oe_n)
      else $error("port");
endmodule // oss_source_switch_chk
bind oss_source_switch oss_source_switch_chk oss_source_switch_chk_i (.*);

// ==== tb/oss_source_switch_tb.sv ====
/* Bench of the source switch. Assumes APB registers at 38, 3C, 40. */
`timescale 1ns/1ns
module oss_source_switch_tb;
   logic core_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, stop_mode = 0, ext_on = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q, r;
   logic pready, cin, cen, src, half, run;
   logic [1:0] fn;
   int bad_count = 0, n_compared = 0, i;
   always #10 core_clk = ~core_clk;
   oss_ext_src oss_ext_src_i (.en(ext_on), .clk(cin));
   oss_source_switch oss_source_switch_i (.core_clk, .nrst, .ce(1'b1), .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr(), .stop_mode,
      .clock_in_pin(cin), .clock_in_enable(cen), .clock_out_pin_o(), .clock_out_pin_oe_n(),
      .clock_out_fn(fn), .source_rate_clock(src), .half_rate_clock(half),
      .internal_osc_run(run));
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk) penable <= 1;
      do @(negedge core_clk); while (pready !== 1'b1);
      @(posedge core_clk);
      q = prdata;
      psel <= 0;
      penable <= 0;
      @(posedge core_clk);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %0t %h %h", $time, g, e);
      end
   endtask
   function automatic logic [2:0] pin_exp(input int c);
      return {c[1:0] != 0, c[1:0] == 3 ? 2'h1 : (c[1:0] == 1 || !c[2]) ? 2'h0 : 2'h2};
   endfunction
   task automatic close_out;
      if (bad_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #1000000 bad_count++;
      close_out;
   end
   initial begin
      r = $urandom(8169);
      repeat (16) @(posedge core_clk);
      nrst <= 1;
      @(posedge core_clk);
      xfer(0, 8'h38, 0);
      chk(q, 32'h80);
      xfer(0, 8'h3C, 0);
      chk(q, 0);
      for (i = 0; i < 6; i++) begin
         r = $urandom & 32'hFF;
         xfer(1, 8'h38, r);
         xfer(0, 8'h38, 0);
         chk(q, r);
      end
      for (i = 0; i < 8; i++) begin
         xfer(1, 8'h40, i);
         repeat (3) @(posedge core_clk);
         chk({cen, fn}, pin_exp(i));
      end
      ext_on <= 1;
      repeat (60) @(posedge core_clk);
      xfer(1, 8'h3C, 1);
      i = 0;
      do xfer(0, 8'h3C, 0); while (q[1] !== 1'b1 && i++ < 300);
      chk(q[1:0], 3);
      chk(run, 0);
      stop_mode <= 1;
      repeat (6) @(posedge core_clk);
      chk(src, 0);
      stop_mode <= 0;
      ext_on <= 0;
      repeat (20) @(posedge core_clk);
      chk(run, 0);
      xfer(0, 8'h44, 0);
      nrst <= 0;
      repeat (4) @(posedge core_clk);
      nrst <= 1;
      @(posedge core_clk);
      chk(run, 1);
      xfer(0, 8'h3C, 0);
      chk(q, 0);
      close_out;
   end
endmodule // oss_source_switch_tb
